// File: sipm_osc_model.sv
// sipm_osc_model: oscillator and pll start-up seen from the power manager
`timescale 1ns/1ps
module sipm_osc_model (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic osc_en,
   input  wire logic slow,
   output logic      osc_ready,
   output logic      pll_lock
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   // start-up count restarts whenever the oscillator is stopped
   assign cnt_d = !osc_en ? 8'h00 : (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
   always_ff @(posedge mclk) begin
      if (rst)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_d;
   end
   // slow mode outlasts every wake delay
   assign osc_ready = cnt_q >= (slow ? 8'h3C : 8'h02);
   assign pll_lock  = osc_ready;
endmodule

// File: sipm_pkg.sv
// sipm_pkg: constants, types and register map of the sleep/idle power manager
package sipm_pkg;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] CTRL_OFFS   = 8'h00;
   localparam logic [7:0] STATUS_OFFS = 8'h04;
   localparam logic [7:0] OSC_OFFS    = 8'h08;
   localparam logic [7:0] DELAY_OFFS  = 8'h0C;

   // control register fields
   localparam int CTRL_CLKSW_BIT   = 0;
   localparam int CTRL_CLKMON_BIT  = 1;
   localparam int CTRL_WDTEN_BIT   = 2;
   localparam int CTRL_BOREN_BIT   = 3;
   localparam int CTRL_LPOSC_BIT   = 4;
   localparam int CTRL_PIDLE_LSB   = 8;
   localparam int NUM_PERIPH       = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // status register fields
   localparam int STAT_IDLE_BIT    = 2;
   localparam int STAT_SLEEP_BIT   = 3;
   localparam int STAT_WDOG_BIT    = 4;
   localparam int STAT_CFAIL_BIT   = 5;
   localparam int STAT_STATE_LSB   = 8;

   // oscillator register fields
   localparam int OSC_CUR_LSB      = 0;
   localparam int OSC_FAM_LSB      = 4;
   localparam int OSC_PRIM_LSB     = 8;

   // ****************************************************************
   // oscillator selections of current_osc_select / osc_family_select_cfg
   // ****************************************************************
   localparam logic [2:0] OSC_LOWRC  = 3'h0;
   localparam logic [2:0] OSC_FASTRC = 3'h1;
   localparam logic [2:0] OSC_LPX  = 3'h2;
   localparam logic [2:0] OSC_PRI  = 3'h3;

   // primary_osc_mode_cfg modes
   localparam logic [4:0] PRIM_EXTCLK = 5'h00;
   localparam logic [4:0] PRIM_EXTRC  = 5'h01;
   localparam logic [4:0] PRIM_XT     = 5'h02;
   localparam logic [4:0] PRIM_PLL    = 5'h03;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_MHZ          = 250;
   localparam int POR_DELAY_US     = 10;
   localparam int POR_DELAY_CYC    = POR_DELAY_US * CLK_MHZ;
   localparam int PWRT_DELAY_US    = 64;
   localparam int PWRT_DELAY_CYC   = PWRT_DELAY_US * CLK_MHZ;
   localparam int LOCK_DELAY_US    = 20;
   localparam int LOCK_DELAY_CYC   = LOCK_DELAY_US * CLK_MHZ;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      SIPM_RUN   = 3'b000,
      SIPM_IDLE  = 3'b001,
      SIPM_SLEEP = 3'b011,
      SIPM_WAKE  = 3'b010,
      SIPM_STALL = 3'b110
   } sipm_state_t;

   typedef struct packed {
      logic       save_req;
      logic       save_idle;
      logic       irq_wake;
      logic       wdt_timeout;
      logic       por;
      logic       brown_out;
      logic       master_clear;
      logic       osc_ready;
      logic       pll_lock;
   } sipm_evt_t;

   typedef struct packed {
      logic       cpu_clk_en;
      logic       periph_clk_en;
      logic       osc_en;
      logic       lowrc_en;
      logic       clkmon_en;
      logic       brown_det_en;
      logic       irq_branch;
      logic       clk_fail_trap;
   } sipm_ctl_t;

endpackage

// File: sipm_top.sv
// sipm_top: sleep/idle power manager with an AXI4-Lite register slave
//
// Notes on behaviour
// - two low-power states, entered only by the power_save_instruction.
// - sleep stops cpu and peripheral clocks and the on-chip oscillator.
// - sleep: clock monitor off; low_power_rc_clock runs while watchdog is enabled.
// - enabled brown-out detection keeps running during sleep.
// - sleep exits on enabled interrupt, any reset, or watchdog time-out.
// - wake restarts prior clock; current_osc_select chooses it with clock switching.
// - wake by power-on or brown-out reset takes oscillator from configuration fields.
// - crystal waits oscillator ready, pll waits lock; all delays apply.
// - external, fast rc, low-power rc, external rc clocks: power_on_delay only.
// - low_power_crystal kept running and reused: power_on_delay only.
// - interrupt wake from sleep branches to the service routine, sets sleep bit.
// - clock dead after delays: trap and fast rc if monitor on, else stall.
// - every reset wakes sleep; master_clear sets sleep bit, brown-out leaves it, por clears it.
// - watchdog wake from sleep sets sleep bit and watchdog_timeout_flag.
// - idle gates cpu clock and peripherals with a clear idle bit; clock source keeps running.
// - each peripheral has its own bit to keep running in idle.
// - idle keeps low_power_rc_clock on while clock-failure detection is enabled.
// - idle exits on enabled interrupt, any reset, or watchdog time-out.
// - idle exit restores cpu clock at once, no delay.
// - interrupt wake from idle branches to the service routine, sets idle bit.
// - master_clear sets idle bit, brown-out leaves it, por clears it.
// - watchdog wake from idle sets idle bit and watchdog_timeout_flag.
// - watchdog time-out in sleep wakes instead of resetting.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module sipm_top #(
   parameter int NUM_PERIPH = sipm_pkg::NUM_PERIPH,
   parameter int POR_CYC    = sipm_pkg::POR_DELAY_CYC,
   parameter int PWRT_CYC   = sipm_pkg::PWRT_DELAY_CYC,
   parameter int LOCK_CYC   = sipm_pkg::LOCK_DELAY_CYC
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire sipm_pkg::sipm_evt_t   evt,
   output sipm_pkg::sipm_ctl_t        ctl,
   output logic [NUM_PERIPH-1:0]      periph_run,
   output logic                       wdt_reset_req,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // ****************************************************************
   // registers
   // ****************************************************************
   sipm_pkg::sipm_state_t state_q, state_d;
   logic [31:0] ctrl_q;
   logic [31:0] oscsel_q;
   logic        idle_flag_q, sleep_flag_q, wdog_flag_q, cfail_q;
   logic [31:0] cnt_q;
   logic        slow_q, pll_q;
   logic        wr_go;
   logic        aw_q, w_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   // ****************************************************************
   // control decode
   // ****************************************************************
   wire clksw_en  = ctrl_q[sipm_pkg::CTRL_CLKSW_BIT];
   wire clkmon_cfg = ctrl_q[sipm_pkg::CTRL_CLKMON_BIT];
   wire wdt_en    = ctrl_q[sipm_pkg::CTRL_WDTEN_BIT];
   wire brown_cfg = ctrl_q[sipm_pkg::CTRL_BOREN_BIT];
   wire lposc_en  = ctrl_q[sipm_pkg::CTRL_LPOSC_BIT];
   wire [2:0] cur_osc   = oscsel_q[sipm_pkg::OSC_CUR_LSB +: 3];
   wire [2:0] fam_osc   = oscsel_q[sipm_pkg::OSC_FAM_LSB +: 3];
   wire [4:0] prim_mode = oscsel_q[sipm_pkg::OSC_PRIM_LSB +: 5];
   wire [2:0] run_osc   = clksw_en ? cur_osc : fam_osc;
   wire keep_lpx  = lposc_en && (run_osc == sipm_pkg::OSC_LPX);

   wire any_rst   = evt.por | evt.brown_out | evt.master_clear;
   wire pwr_rst   = evt.por | evt.brown_out;
   wire in_sleep  = (state_q == sipm_pkg::SIPM_SLEEP);
   wire in_idle   = (state_q == sipm_pkg::SIPM_IDLE);
   wire lowpwr    = in_sleep | in_idle;
   wire wake_evt  = evt.irq_wake | evt.wdt_timeout | any_rst;

   // wake oscillator: configuration after power resets or with clock switching off, else current selection
   wire [2:0] wake_osc = (pwr_rst || !clksw_en) ? fam_osc : cur_osc;
   wire wake_pri   = (wake_osc == sipm_pkg::OSC_PRI);
   wire wake_xtal  = wake_pri && (prim_mode == sipm_pkg::PRIM_XT);
   wire wake_pll   = wake_pri && (prim_mode == sipm_pkg::PRIM_PLL);
   wire wake_lpx   = (wake_osc == sipm_pkg::OSC_LPX);
   wire lpx_kept   = wake_lpx && lposc_en;
   wire wake_slow  = (wake_xtal | wake_pll | wake_lpx) && !lpx_kept;
   wire [31:0] wake_len = wake_slow ? 32'(POR_CYC + PWRT_CYC + (wake_pll ? LOCK_CYC : 0))
                                    : 32'(POR_CYC);
   wire clk_good   = pll_q ? evt.pll_lock : (slow_q ? evt.osc_ready : 1'b1);
   wire delay_done = (cnt_q == 32'h0000_0000);

   // ****************************************************************
   // state machine
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         sipm_pkg::SIPM_RUN: begin
            if (evt.save_req) begin
               state_d = evt.save_idle ? sipm_pkg::SIPM_IDLE
                                       : sipm_pkg::SIPM_SLEEP;
            end
         end
         sipm_pkg::SIPM_IDLE: begin
            if (wake_evt) begin
               state_d = sipm_pkg::SIPM_RUN;
            end
         end
         sipm_pkg::SIPM_SLEEP: begin
            if (wake_evt) begin
               state_d = sipm_pkg::SIPM_WAKE;
            end
         end
         sipm_pkg::SIPM_WAKE: begin
            if (delay_done) begin
               if (clk_good) begin
                  state_d = sipm_pkg::SIPM_RUN;
               end else if (clkmon_cfg) begin
                  state_d = sipm_pkg::SIPM_RUN;
               end else begin
                  state_d = sipm_pkg::SIPM_STALL;
               end
            end
         end
         sipm_pkg::SIPM_STALL: begin
            if (clk_good) begin
               state_d = sipm_pkg::SIPM_RUN;
            end
         end
         default: state_d = sipm_pkg::SIPM_RUN;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= sipm_pkg::SIPM_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // wake delay counter and remembered clock kind
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q  <= 32'h0000_0000;
         slow_q <= 1'b0;
         pll_q  <= 1'b0;
      end else if (in_sleep && wake_evt) begin
         cnt_q  <= wake_len - 32'h0000_0001;
         slow_q <= wake_slow;
         pll_q  <= wake_pll && !lpx_kept;
      end else if (!delay_done) begin
         cnt_q  <= cnt_q - 32'h0000_0001;
      end
   end

   // ****************************************************************
   // clock and peripheral gating
   // ****************************************************************
   wire stop_all = in_sleep | (state_q == sipm_pkg::SIPM_WAKE)
                 | (state_q == sipm_pkg::SIPM_STALL);
   wire trap_now = (state_q == sipm_pkg::SIPM_WAKE) && delay_done && !clk_good && clkmon_cfg;

   assign ctl.cpu_clk_en    = !stop_all && !in_idle;
   assign ctl.periph_clk_en = !stop_all;
   assign ctl.osc_en        = !in_sleep || keep_lpx;
   assign ctl.lowrc_en      = in_sleep ? wdt_en : (wdt_en | clkmon_cfg);
   assign ctl.clkmon_en     = clkmon_cfg && !in_sleep;
   assign ctl.brown_det_en  = brown_cfg;
   assign ctl.irq_branch    = lowpwr && evt.irq_wake;
   assign ctl.clk_fail_trap = trap_now;
   assign wdt_reset_req     = evt.wdt_timeout && !lowpwr;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
         assign periph_run[gi] = ctl.periph_clk_en
                               && (!in_idle || ctrl_q[sipm_pkg::CTRL_PIDLE_LSB + gi]);
      end
   endgenerate

   // ****************************************************************
   // status flags; hardware set wins over software clear
   // ****************************************************************
   wire set_sleep = (in_sleep && (evt.irq_wake || evt.wdt_timeout))
                  || (in_sleep && evt.master_clear);
   wire set_idle  = (in_idle && (evt.irq_wake || evt.wdt_timeout))
                  || (in_idle && evt.master_clear);
   wire set_wdog  = lowpwr && evt.wdt_timeout;
   wire st_wr     = wr_go && (awaddr_q == sipm_pkg::STATUS_OFFS) && wstrb_q[0];

   always_ff @(posedge mclk) begin
      if (rst) begin
         sleep_flag_q <= 1'b0;
         idle_flag_q  <= 1'b0;
         wdog_flag_q  <= 1'b0;
         cfail_q      <= 1'b0;
      end else begin
         sleep_flag_q <= evt.por ? 1'b0 : (set_sleep | (sleep_flag_q & ~(st_wr
                         & wdata_q[sipm_pkg::STAT_SLEEP_BIT])));
         idle_flag_q  <= evt.por ? 1'b0 : (set_idle | (idle_flag_q & ~(st_wr
                         & wdata_q[sipm_pkg::STAT_IDLE_BIT])));
         wdog_flag_q  <= evt.por ? 1'b0 : (set_wdog | (wdog_flag_q & ~(st_wr
                         & wdata_q[sipm_pkg::STAT_WDOG_BIT])));
         cfail_q      <= trap_now | (cfail_q & ~(st_wr & wdata_q[sipm_pkg::STAT_CFAIL_BIT]));
      end
   end

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   assign wr_go = aw_q && w_q && !s_axi_bvalid;
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_known = (awaddr_q == sipm_pkg::CTRL_OFFS) || (awaddr_q == sipm_pkg::STATUS_OFFS)
                 || (awaddr_q == sipm_pkg::OSC_OFFS);
   wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] stat_word = {20'h0_0000, 1'b0, state_q, 2'b00, cfail_q, wdog_flag_q,
                            sleep_flag_q, idle_flag_q, 2'b00};
   wire [7:0]  ra = {s_axi_araddr[7:2], 2'b00};
   wire rd_known = (ra == sipm_pkg::CTRL_OFFS) || (ra == sipm_pkg::STATUS_OFFS)
                 || (ra == sipm_pkg::OSC_OFFS) || (ra == sipm_pkg::DELAY_OFFS);
   wire [31:0] rd_word = (ra == sipm_pkg::CTRL_OFFS)   ? ctrl_q
                       : (ra == sipm_pkg::STATUS_OFFS) ? stat_word
                       : (ra == sipm_pkg::OSC_OFFS)    ? oscsel_q
                       : (ra == sipm_pkg::DELAY_OFFS)  ? cnt_q : 32'h0000_0000;

   always_ff @(posedge mclk) begin
      if (rst) begin
         aw_q <= 1'b0;
         w_q  <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         ctrl_q   <= sipm_pkg::CTRL_RESET;
         oscsel_q <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
            if (awaddr_q == sipm_pkg::CTRL_OFFS) begin
               ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
            end
            if (awaddr_q == sipm_pkg::OSC_OFFS) begin
               oscsel_q <= ((oscsel_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_1F77;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (trap_now) begin
            oscsel_q[sipm_pkg::OSC_CUR_LSB +: 3] <= sipm_pkg::OSC_FASTRC;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_idle_cpu_gate: assert property (@(posedge mclk) disable iff (rst)
      in_idle |-> !ctl.cpu_clk_en && ctl.periph_clk_en && ctl.osc_en)
      else $error("idle gating wrong");
   chk_sleep_clk_off: assert property (@(posedge mclk) disable iff (rst)
      in_sleep |-> !ctl.cpu_clk_en && !ctl.periph_clk_en)
      else $error("sleep clocks not stopped");
   chk_entry_instr: assert property (@(posedge mclk) disable iff (rst)
      (state_q == sipm_pkg::SIPM_RUN) && !evt.save_req |=> !lowpwr)
      else $error("low power entered without instruction");
   chk_entry_operand: assert property (@(posedge mclk) disable iff (rst)
      (state_q == sipm_pkg::SIPM_RUN) && evt.save_req && evt.save_idle |=> in_idle)
      else $error("idle operand ignored");
   chk_idle_wake_fast: assert property (@(posedge mclk) disable iff (rst)
      in_idle && wake_evt |=> ctl.cpu_clk_en)
      else $error("idle wake delayed");
   chk_wdt_wake_flags: assert property (@(posedge mclk) disable iff (rst)
      in_sleep && evt.wdt_timeout && !evt.por |=> sleep_flag_q && wdog_flag_q)
      else $error("watchdog wake flags missing");
   chk_por_clear_flag: assert property (@(posedge mclk) disable iff (rst)
      evt.por |=> !sleep_flag_q && !idle_flag_q)
      else $error("power-on reset left flags");
   chk_fast_wake_len: assert property (@(posedge mclk) disable iff (rst)
      in_sleep && wake_evt && !wake_slow |=> cnt_q == 32'(POR_CYC - 1))
      else $error("fast wake delay wrong");
   chk_wdt_no_reset: assert property (@(posedge mclk) disable iff (rst)
      in_sleep |-> !wdt_reset_req)
      else $error("watchdog reset in sleep");
   chk_trap_osc_swap: assert property (@(posedge mclk) disable iff (rst)
      trap_now |=> cur_osc == sipm_pkg::OSC_FASTRC)
      else $error("trap kept old oscillator");
   chk_stall_hold: assert property (@(posedge mclk) disable iff (rst)
      (state_q == sipm_pkg::SIPM_STALL) |-> !ctl.cpu_clk_en && ctl.osc_en)
      else $error("stall released clock");
   chk_sleep_wake_go: assert property (@(posedge mclk) disable iff (rst)
      in_sleep && wake_evt |=> (state_q == sipm_pkg::SIPM_WAKE))
      else $error("sleep wake event ignored");
   chk_sleep_osc_off: assert property (@(posedge mclk) disable iff (rst)
      in_sleep && !lposc_en |-> !ctl.osc_en)
      else $error("oscillator left on in sleep");
   chk_sleep_lowrc: assert property (@(posedge mclk) disable iff (rst)
      in_sleep |-> (ctl.lowrc_en == wdt_en) && !ctl.clkmon_en)
      else $error("sleep low-power rc wrong");

endmodule

// File: testbench.sv
// testbench: self-checking bench of the sleep/idle power manager
`timescale 1ns/1ps
module testbench;
   // ****************************************************************
   // signals
   // ****************************************************************
   localparam int P = 4;
   localparam int W = 8;
   localparam int L = 4;
   logic                mclk, rst, slow, rdy, lock, wrq, irq_seen, trap, wrs;
   logic [3:0]          wstrb;
   logic [8:0]          ev;
   sipm_pkg::sipm_evt_t evt;
   sipm_pkg::sipm_ctl_t ctl;
   logic [7:0]          prun, awaddr, araddr;
   logic [31:0]         wdata, rdata;
   logic                awvalid, awready, wvalid, wready, bvalid, bready;
   logic                arvalid, arready, rvalid, rready;
   logic [1:0]          bresp, rresp;
   int                  mismatches, check_count, cyc;
   always_comb begin
      evt = sipm_pkg::sipm_evt_t'(ev);
      evt.osc_ready = rdy;
      evt.pll_lock = lock;
   end
   sipm_top #(.POR_CYC(P), .PWRT_CYC(W), .LOCK_CYC(L)) i_dut (.mclk(mclk), .rst(rst),
      .evt(evt), .ctl(ctl), .periph_run(prun), .wdt_reset_req(wrq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   sipm_osc_model i_osc (.mclk(mclk), .rst(rst), .osc_en(ctl.osc_en), .slow(slow),
      .osc_ready(rdy), .pll_lock(lock));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(negedge mclk) begin
      if (ctl.irq_branch === 1'b1) irq_seen <= 1'b1;
      if (ctl.clk_fail_trap === 1'b1) trap <= 1'b1;
      if (wrq === 1'b1) wrs <= 1'b1;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude;
      end
   end
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic c, input string m);
      check_count++;
      if (c !== 1'b1) begin
         mismatches++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ah, wh, bh;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(negedge mclk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         r  = bresp;
         @(posedge mclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end while (!bh);
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(negedge mclk);
         ah = arvalid & arready;
         rh = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge mclk);
         if (ah) arvalid <= 1'b0;
      end while (!rh);
      rready <= 1'b0;
   endtask
   task automatic pls(input logic [8:0] p);
      @(posedge mclk);
      ev <= p;
      @(posedge mclk);
      ev <= '0;
   endtask
   task automatic wk(output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (ctl.cpu_clk_en !== 1'b1 && n < 300);
   endtask
   task automatic st(output logic [31:0] d);
      logic [1:0] r;
      axr(sipm_pkg::STATUS_OFFS, d, r);
   endtask
   task automatic clr;
      logic [1:0] r;
      axw(sipm_pkg::STATUS_OFFS, 32'h0000_00FF, r);
      irq_seen = 1'b0;
      trap = 1'b0;
      wrs = 1'b0;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      axr(sipm_pkg::CTRL_OFFS, d, r);
      chk(d === sipm_pkg::CTRL_RESET && ctl.cpu_clk_en === 1'b1, "reset state");
      axr(8'h40, d, r);
      chk(r === 2'b10 && d === 32'h0000_0000, "unmapped read");
      axw(8'h40, 32'hFFFF_FFFF, r);
      chk(r === 2'b10, "unmapped write");
      wstrb <= 4'h1;
      axw(sipm_pkg::CTRL_OFFS, 32'hFFFF_FFFF, r);
      wstrb <= 4'hF;
      axr(sipm_pkg::CTRL_OFFS, d, r);
      chk(d === 32'h0000_00FF, "byte strobe");
      axr(sipm_pkg::DELAY_OFFS, d, r);
      chk(d === 32'h0000_0000 && r === 2'b00, "delay idle");
      $display("done reset");
   endtask
   task automatic t_idle;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      axw(sipm_pkg::CTRL_OFFS, 32'h0000_A506, r);
      clr;
      pls(9'h180);
      @(negedge mclk);
      chk(ctl.cpu_clk_en === 1'b0 && ctl.periph_clk_en && ctl.osc_en, "idle gate");
      chk(prun === 8'hA5 && ctl.lowrc_en === 1'b1, "idle runs");
      chk(ctl.clkmon_en === 1'b1, "idle monitor");
      pls(9'h040);
      wk(n);
      chk(n == 1 && irq_seen === 1'b1, "idle irq wake");
      st(d);
      chk(d[sipm_pkg::STAT_IDLE_BIT] === 1'b1, "idle bit");
      clr;
      pls(9'h180);
      pls(9'h020);
      wk(n);
      st(d);
      chk(n == 1 && d[4:2] === 3'b101 && !wrs, "idle wdt wake");
      clr;
      pls(9'h180);
      pls(9'h004);
      wk(n);
      st(d);
      chk(n == 1 && d[4:2] === 3'b001, "idle master_clear_pin wake");
      $display("done idle");
   endtask
   task automatic t_sleep;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      axw(sipm_pkg::CTRL_OFFS, 32'h0000_000C, r);
      clr;
      pls(9'h100);
      @(negedge mclk);
      chk(!ctl.cpu_clk_en && !ctl.periph_clk_en && !ctl.osc_en, "sleep gate");
      chk(ctl.clkmon_en === 1'b0 && ctl.lowrc_en === 1'b1, "sleep lowrc");
      chk(ctl.brown_det_en === 1'b1, "sleep brown-out");
      pls(9'h020);
      wk(n);
      chk(n >= P - 1 && n <= P + 3 && !wrs, "sleep wdt wake");
      st(d);
      chk(d[4:3] === 2'b11, "sleep wdt bits");
      pls(9'h010);
      st(d);
      chk(d[3:2] === 2'b00, "por clears");
      clr;
      pls(9'h100);
      pls(9'h004);
      wk(n);
      st(d);
      chk(n <= P + 3 && d[sipm_pkg::STAT_SLEEP_BIT] === 1'b1, "sleep master_clear_pin");
      pls(9'h020);
      chk(wrs === 1'b1, "run wdt reset");
      $display("done sleep");
   endtask
   task automatic t_osc;
      logic [2:0]  cs[8] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2};
      logic [4:0]  fm[8] = '{5'h0, 5'h0, 5'h0, 5'h1, 5'h2, 5'h3, 5'h0, 5'h0};
      logic        kp[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      int          ln[8] = '{P, P, P, P, P + W, P + W + L, P, P + W};
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      for (int i = 0; i < 8; i++) begin
         axw(sipm_pkg::CTRL_OFFS, {27'h0, kp[i], 4'h1}, r);
         axw(sipm_pkg::OSC_OFFS, {19'h0, fm[i], 5'h0, cs[i]}, r);
         clr;
         pls(9'h100);
         pls(9'h040);
         wk(n);
         chk(n >= ln[i] - 1 && n <= ln[i] + 3, "wake delay");
         st(d);
         chk(d[sipm_pkg::STAT_SLEEP_BIT] === 1'b1 && irq_seen === 1'b1, "irq wake");
      end
      $display("done osc");
   endtask
   task automatic t_fail;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      slow = 1'b1;
      axw(sipm_pkg::CTRL_OFFS, 32'h0000_0001, r);
      axw(sipm_pkg::OSC_OFFS, 32'h0000_0203, r);
      clr;
      pls(9'h100);
      pls(9'h004);
      wk(n);
      chk(n > P + W + 20 && n < 300 && trap === 1'b0, "stall");
      axw(sipm_pkg::CTRL_OFFS, 32'h0000_0003, r);
      clr;
      pls(9'h100);
      pls(9'h040);
      wk(n);
      st(d);
      chk(n <= P + W + 3 && trap && d[sipm_pkg::STAT_CFAIL_BIT], "clock trap");
      axr(sipm_pkg::OSC_OFFS, d, r);
      chk(d === 32'h0000_0201, "trap to fast rc");
      slow = 1'b0;
      $display("done fail");
   endtask
   initial begin
      rst = 1'b1;
      ev = '0;
      slow = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, irq_seen, trap, wrs} = '0;
      wstrb = 4'hF;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_idle;
      t_sleep;
      t_osc;
      t_fail;
      conclude;
   end
endmodule
